// File: verilog/sensor_id_addr_result_regs.sv
// shared offset/limit byte, target address, identity and result registers
`timescale 1ns/1ps
// Summary of operation
// (R1) select 0,1,3: byte is second offset
// (R2) select 2, angle off: Z high limit
// (R3) shared byte read as signed 8-bit
// (R4) strap pin picks default address 34h-37h
// (R5) address field bits 7..1 writable
// (R6) bit 0 chooses strap or programmed address
// (R7) version code in bits 3..2, rest zero
// (R8) fixed 16-bit maker code, low then high
// (R9) temperature result high 10h, low 11h
// (R10) X result high 12h, low 13h
// (R11) Y result high 14h, low 15h
// (R12) result bytes read-only, 00h after reset
// (R13) writes to read-only registers ignored
module sensor_id_addr_result_regs
  import sensor_regs_pkg::*;
#(
  // value is arbitrary
  parameter logic [1:0]  VARIANT_CODE = 2'h1,
  // value is arbitrary
  parameter logic [15:0] MAKER_CODE   = 16'hA5C3
)
(
  input  wire logic                               clk,
  input  wire logic                               reset,
  input  wire sensor_regs_pkg::strap_t            strap_sel,
  input  wire logic                               reg_wr_en,
  input  wire logic                               reg_rd_en,
  input  wire logic [sensor_regs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [sensor_regs_pkg::DATA_W-1:0] reg_wdata,
  output logic      [sensor_regs_pkg::DATA_W-1:0] reg_rdata,
  output logic                                    reg_rd_valid,
  input  wire logic [1:0]                         threshold_select,
  input  wire logic [1:0]                         angle_enable,
  input  wire logic                               conv_valid,
  input  wire sensor_regs_pkg::result_ch_t        conv_channel,
  input  wire logic [sensor_regs_pkg::RESULT_W-1:0] conv_data,
  output logic      [6:0]                         target_address,
  output logic      [sensor_regs_pkg::RESULT_W-1:0] second_offset_or_z_high_limit,
  output logic                                    second_offset_active,
  output logic                                    z_high_limit_active
);
  result_store_if rs ();

  result_store u_store (
    .clk   (clk),
    .reset (reset),
    .bus   (rs.store)
  );

  // strap synchroniser and capture
  logic [1:0]  strap_meta_r;
  logic [1:0]  strap_sync_r;
  logic [1:0]  strap_meta_nxt;
  logic [1:0]  strap_sync_nxt;
  logic [1:0]  strap_cap_r;
  logic [1:0]  strap_cap_nxt;
  logic        strap_done_r;
  logic        strap_done_nxt;

  // configuration
  logic [7:0]  shared_r;
  logic [7:0]  shared_nxt;
  logic [7:0]  addr_cfg_r;
  logic [7:0]  addr_cfg_nxt;

  // outputs
  logic [6:0]  target_r;
  logic [6:0]  target_nxt;
  logic [15:0] limit_r;
  logic [15:0] limit_nxt;
  logic        offset_act_r;
  logic        offset_act_nxt;
  logic        limit_act_r;
  logic        limit_act_nxt;

  // read pipeline
  logic        rd_pend_r;
  logic        rd_pend_nxt;
  logic        rd_res_r;
  logic        rd_res_nxt;
  logic        rd_hi_r;
  logic        rd_hi_nxt;
  logic [7:0]  rd_pre_r;
  logic [7:0]  rd_pre_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;

  logic [6:0]  strap_addr;
  logic        result_hit;
  logic [7:0]  result_ofs;

  always_comb
  begin
    case (strap_t'(strap_cap_r)) // R4
      STRAP_GND: strap_addr = STRAP_ADDR_GND;
      STRAP_VCC: strap_addr = STRAP_ADDR_VCC;
      STRAP_SCL: strap_addr = STRAP_ADDR_SCL;
      STRAP_SDA: strap_addr = STRAP_ADDR_SDA;
      default:   strap_addr = STRAP_ADDR_GND;
    endcase
  end

  // strap is caught once, on the first cycle after the reset is released
  // later pin changes are ignored until the next reset
  always_comb
  begin
    strap_cap_nxt  = strap_cap_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r)
      strap_cap_nxt = strap_sync_r; // R4
  end

  // two-flop synchroniser for the asynchronous strap pin; logic reads only the second
  // flop, and no reset is given so the pin state has settled by the time reset lifts
  always_comb
  begin
    strap_meta_nxt = strap_sel;
    strap_sync_nxt = strap_meta_r;
  end

  always_ff @(posedge clk)
  begin
    strap_meta_r <= strap_meta_nxt;
    strap_sync_r <= strap_sync_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_cap_r  <= STRAP_GND;
      strap_done_r <= 1'b0;
    end
    else
    begin
      strap_cap_r  <= strap_cap_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // only the shared byte and the address register accept writes
  always_comb
  begin
    shared_nxt   = shared_r;
    addr_cfg_nxt = addr_cfg_r;
    if (reg_wr_en)
    begin
      case (reg_addr)
        OFS_SHARED: shared_nxt   = reg_wdata;
        OFS_ADDR:   addr_cfg_nxt = reg_wdata; // R5
        // identity and result offsets are read-only; such a write is dropped
        OFS_VERSION, OFS_MAKER_LO, OFS_MAKER_HI,
        OFS_TEMP_HI, OFS_TEMP_LO, OFS_X_HI, OFS_X_LO, OFS_Y_HI, OFS_Y_LO:
        begin
          shared_nxt   = shared_r; // R13
          addr_cfg_nxt = addr_cfg_r; // R13
        end
        default:    shared_nxt   = shared_r;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      shared_r   <= RST_SHARED;
      addr_cfg_r <= RST_ADDR;
    end
    else
    begin
      shared_r   <= shared_nxt;
      addr_cfg_r <= addr_cfg_nxt;
    end
  end

  // target address group
  always_comb
  begin
    target_nxt = strap_addr;
    if (addr_cfg_r[ADDR_SRC_BIT]) // R6
      target_nxt = addr_cfg_r[ADDR_FIELD_MSB:ADDR_FIELD_LSB]; // R5
  end

  always_ff @(posedge clk)
  begin
    // shows the ground address until the captured strap has passed through
    if (reset)
      target_r <= STRAP_ADDR_GND;
    else
      target_r <= target_nxt;
  end

  // shared byte group; the mode fields are same-clock levels from other registers
  always_comb
  begin
    limit_nxt      = {{8{shared_r[7]}}, shared_r}; // R3
    offset_act_nxt = (threshold_select != THRESHOLD_SELECT_LIMIT); // R1
    limit_act_nxt  = (threshold_select == THRESHOLD_SELECT_LIMIT)
                     && (angle_enable == ANGLE_OFF); // R2
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      limit_r      <= RST_RESULT;
      offset_act_r <= 1'b0;
      limit_act_r  <= 1'b0;
    end
    else
    begin
      limit_r      <= limit_nxt;
      offset_act_r <= offset_act_nxt;
      limit_act_r  <= limit_act_nxt;
    end
  end

  // conversion engine writes whole words; the bus never reaches the store's write port
  assign rs.wr_en   = conv_valid; // R13
  assign rs.wr_idx  = conv_channel; // R9 R10 R11
  assign rs.wr_data = conv_data;

  // offsets past the Y result, like any other unmapped offset, read back as zero
  assign result_hit = (reg_addr >= OFS_TEMP_HI) && (reg_addr <= OFS_Y_LO);
  assign result_ofs = reg_addr - OFS_TEMP_HI;
  assign rs.rd_idx  = result_ofs[2:1]; // R9 R10 R11

  // read request group: the store answers one cycle after the request edge
  always_comb
  begin
    rd_pend_nxt = reg_rd_en;
    rd_res_nxt  = result_hit;
    rd_hi_nxt   = ~result_ofs[0]; // R9 R10 R11
    rd_pre_nxt  = READ_ZERO;
    // the address register reads back whole, source bit included
    case (reg_addr)
      OFS_SHARED:   rd_pre_nxt = shared_r;
      OFS_ADDR:     rd_pre_nxt = addr_cfg_r;
      OFS_VERSION:  rd_pre_nxt = 8'(VARIANT_CODE) << VERSION_LSB; // R7
      OFS_MAKER_LO: rd_pre_nxt = MAKER_CODE[7:0]; // R8
      OFS_MAKER_HI: rd_pre_nxt = MAKER_CODE[15:8]; // R8
      default:      rd_pre_nxt = READ_ZERO;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_pend_r <= 1'b0;
      rd_res_r  <= 1'b0;
      rd_hi_r   <= 1'b0;
      rd_pre_r  <= READ_ZERO;
    end
    else
    begin
      rd_pend_r <= rd_pend_nxt;
      rd_res_r  <= rd_res_nxt;
      rd_hi_r   <= rd_hi_nxt;
      rd_pre_r  <= rd_pre_nxt;
    end
  end

  // read answer group: no snapshot of the other half is kept, so a conversion
  // landing between two byte reads of one word may mix old and new bytes
  always_comb
  begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = rd_pend_r;
    if (rd_pend_r)
    begin
      if (rd_res_r)
        rdata_nxt = rd_hi_r ? rs.rd_data[15:8] : rs.rd_data[7:0]; // R12
      else
        rdata_nxt = rd_pre_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_r  <= READ_ZERO;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // every output leaves straight from its register
  assign reg_rdata                     = rdata_r;
  assign reg_rd_valid                  = rvalid_r;
  assign target_address                = target_r;
  assign second_offset_or_z_high_limit = limit_r;
  assign second_offset_active          = offset_act_r;
  assign z_high_limit_active           = limit_act_r;
endmodule : sensor_id_addr_result_regs

// File: verilog/sensor_regs_pkg.sv
// register offsets, reset values and field layout for the id, address and result slice
package sensor_regs_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned RESULT_W      = 16;
  localparam int unsigned RESULT_CNT    = 3;

  localparam logic [7:0]  OFS_SHARED    = 8'h0B;
  localparam logic [7:0]  OFS_ADDR      = 8'h0C;
  localparam logic [7:0]  OFS_VERSION   = 8'h0D;
  localparam logic [7:0]  OFS_MAKER_LO  = 8'h0E;
  localparam logic [7:0]  OFS_MAKER_HI  = 8'h0F;
  localparam logic [7:0]  OFS_TEMP_HI   = 8'h10;
  localparam logic [7:0]  OFS_TEMP_LO   = 8'h11;
  localparam logic [7:0]  OFS_X_HI      = 8'h12;
  localparam logic [7:0]  OFS_X_LO      = 8'h13;
  localparam logic [7:0]  OFS_Y_HI      = 8'h14;
  localparam logic [7:0]  OFS_Y_LO      = 8'h15;

  localparam logic [7:0]  RST_SHARED    = 8'h00;
  localparam logic [7:0]  RST_ADDR      = 8'h00;
  localparam logic [15:0] RST_RESULT    = 16'h0000;
  localparam logic [7:0]  READ_ZERO     = 8'h00;

  // target address register layout
  localparam int unsigned ADDR_FIELD_LSB = 1;
  localparam int unsigned ADDR_FIELD_MSB = 7;
  localparam int unsigned ADDR_SRC_BIT   = 0;
  // version field position
  localparam int unsigned VERSION_LSB    = 2;

  localparam logic [6:0]  STRAP_ADDR_GND = 7'h34;
  localparam logic [6:0]  STRAP_ADDR_VCC = 7'h35;
  localparam logic [6:0]  STRAP_ADDR_SCL = 7'h36;
  localparam logic [6:0]  STRAP_ADDR_SDA = 7'h37;

  typedef enum logic [1:0] {
    STRAP_GND = 2'h0,
    STRAP_VCC = 2'h1,
    STRAP_SCL = 2'h2,
    STRAP_SDA = 2'h3
  } strap_t;

  typedef enum logic [1:0] {
    CH_TEMP = 2'h0,
    CH_X    = 2'h1,
    CH_Y    = 2'h2
  } result_ch_t;

  localparam logic [1:0]  THRESHOLD_SELECT_LIMIT  = 2'h2;
  localparam logic [1:0]  ANGLE_OFF      = 2'h0;
endpackage : sensor_regs_pkg

// File: verilog/result_store_if.sv
// carrier between the register slice and its result store
`timescale 1ns/1ps
interface result_store_if;
  import sensor_regs_pkg::*;
  logic                wr_en;
  logic [1:0]          wr_idx;
  logic [RESULT_W-1:0] wr_data;
  logic [1:0]          rd_idx;
  logic [RESULT_W-1:0] rd_data;

  modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : result_store_if

// File: verilog/result_store.sv
// three 16-bit conversion result words with a registered read port
`timescale 1ns/1ps
module result_store
  import sensor_regs_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    reset,
  result_store_if.store bus
);
  logic [RESULT_W-1:0] word_r   [RESULT_CNT];
  logic [RESULT_W-1:0] word_nxt [RESULT_CNT];
  logic [RESULT_W-1:0] rd_data_r;
  logic [RESULT_W-1:0] rd_data_nxt;

  genvar g;
  generate
    for (g = 0; g < RESULT_CNT; g++)
    begin : g_word
      always_comb
      begin
        word_nxt[g] = word_r[g];
        if (bus.wr_en && (bus.wr_idx == 2'(g)))
          word_nxt[g] = bus.wr_data;
      end

      always_ff @(posedge clk)
      begin
        if (reset)
          word_r[g] <= RST_RESULT;
        else
          word_r[g] <= word_nxt[g];
      end
    end
  endgenerate

  always_comb
  begin
    // index 3 is not a result word; reads back as zero
    rd_data_nxt = RST_RESULT;
    if (bus.rd_idx < 2'(RESULT_CNT))
      rd_data_nxt = word_r[bus.rd_idx];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rd_data_r <= RST_RESULT;
    else
      rd_data_r <= rd_data_nxt;
  end

  assign bus.rd_data = rd_data_r;
endmodule : result_store

// File: tb/conv_source.sv
// conversion engine stand-in that issues single-cycle result writes
`timescale 1ns/1ps
module conv_source
  import sensor_regs_pkg::*;
(
  input  wire logic                         clk,
  output logic                              conv_valid,
  output sensor_regs_pkg::result_ch_t       conv_channel,
  output logic [sensor_regs_pkg::RESULT_W-1:0] conv_data
);
  initial
  begin
    conv_valid   = 1'b0;
    conv_channel = CH_TEMP;
    conv_data    = 16'h0000;
  end
  // between results the data bus shows the inverse of the last word,
  // so a stray sample is never the word just written
  task automatic convert(input logic [1:0] ch, input logic [15:0] d);
    @(posedge clk);
    conv_valid   <= 1'b1;
    conv_channel <= result_ch_t'(ch);
    conv_data    <= d;
    @(posedge clk);
    conv_valid <= 1'b0;
    conv_data  <= ~d;
  endtask : convert
endmodule : conv_source

// File: tb/regs_checker.sv
// concurrent checks on the register slice ports
`timescale 1ns/1ps
module regs_checker
  import sensor_regs_pkg::*;
#(
  parameter logic [1:0]  VARIANT_CODE = 2'h1,
  parameter logic [15:0] MAKER_CODE   = 16'hA5C3
)
(
  input wire logic                   clk,
  input wire logic                   reset,
  input wire sensor_regs_pkg::strap_t strap_sel,
  input wire logic                   reg_wr_en,
  input wire logic                   reg_rd_en,
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   reg_rd_valid,
  input wire logic [1:0]             threshold_select,
  input wire logic [1:0]             angle_enable,
  input wire logic [6:0]             target_address,
  input wire logic [15:0]            second_offset_or_z_high_limit,
  input wire logic                   second_offset_active,
  input wire logic                   z_high_limit_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_rd_lat; reg_rd_en |-> ##2 reg_rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_ver;
    reg_rd_en && reg_addr == OFS_VERSION |-> ##2 reg_rdata == {4'h0, VARIANT_CODE, 2'h0};
  endproperty
  a_ver: assert property (p_ver) else $error("version byte wrong");
  property p_mk_lo; reg_rd_en && reg_addr == OFS_MAKER_LO |-> ##2 reg_rdata == MAKER_CODE[7:0];
  endproperty
  a_mk_lo: assert property (p_mk_lo) else $error("maker low byte wrong");
  property p_mk_hi; reg_rd_en && reg_addr == OFS_MAKER_HI |-> ##2 reg_rdata == MAKER_CODE[15:8];
  endproperty
  a_mk_hi: assert property (p_mk_hi) else $error("maker high byte wrong");
  property p_ofs;
    !$past(reset) |-> second_offset_active == ($past(threshold_select) != THRESHOLD_SELECT_LIMIT);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset flag wrong");
  property p_zl;
    !$past(reset) |-> z_high_limit_active ==
      ($past(threshold_select) == THRESHOLD_SELECT_LIMIT && $past(angle_enable) == ANGLE_OFF);
  endproperty
  a_zl: assert property (p_zl) else $error("limit flag wrong");
  property p_sext;
    reg_wr_en && reg_addr == OFS_SHARED |-> ##2
      second_offset_or_z_high_limit == {{8{$past(reg_wdata[7], 2)}}, $past(reg_wdata, 2)};
  endproperty
  a_sext: assert property (p_sext) else $error("shared byte not sign extended");
  property p_strap; $fell(reset) |-> ##3 target_address == {5'h0D, strap_sel}; endproperty
  a_strap: assert property (p_strap) else $error("strap address wrong");
  property p_prog;
    reg_wr_en && reg_addr == OFS_ADDR && reg_wdata[0]
      |-> ##2 target_address == $past(reg_wdata[7:1], 2);
  endproperty
  a_prog: assert property (p_prog) else $error("programmed address not used");
  c_zl: cover property (z_high_limit_active);
  c_ver: cover property (reg_rd_en && reg_addr == OFS_VERSION);
  c_sda: cover property ($fell(reset) ##3 target_address == STRAP_ADDR_SDA);
endmodule : regs_checker

bind sensor_id_addr_result_regs regs_checker
  #(.VARIANT_CODE(VARIANT_CODE), .MAKER_CODE(MAKER_CODE))
  u_chk (.clk(clk), .reset(reset), .strap_sel(strap_sel), .reg_wr_en(reg_wr_en),
         .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
         .reg_rd_valid(reg_rd_valid), .threshold_select(threshold_select),
         .angle_enable(angle_enable), .target_address(target_address),
         .second_offset_or_z_high_limit(second_offset_or_z_high_limit),
         .second_offset_active(second_offset_active), .z_high_limit_active(z_high_limit_active));

// File: tb/sensor_id_addr_result_regs_tb_top.sv
// self-checking bench for the id, address and result register slice
`timescale 1ns/1ps
module sensor_id_addr_result_regs_tb_top;
  import sensor_regs_pkg::*;
  localparam logic [1:0]  VC = 2'h3;     // value is arbitrary
  localparam logic [15:0] MC = 16'h3C96; // value is arbitrary
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  strap_t      strap_sel = STRAP_GND;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [1:0]  threshold_select = 2'h0;
  logic [1:0]  angle_enable = 2'h0;
  logic        conv_valid;
  result_ch_t  conv_channel;
  logic [15:0] conv_data;
  logic [7:0]  reg_rdata;
  logic        reg_rd_valid;
  logic [6:0]  target_address;
  logic [15:0] limit;
  logic        ofs_act;
  logic        zl_act;
  logic [7:0]  mdl [256];
  int          err_count = 0;
  int          checks = 0;
  int          seed = 41;
  logic [15:0] d;
  initial forever #20 clk = ~clk;
  sensor_id_addr_result_regs #(.VARIANT_CODE(VC), .MAKER_CODE(MC)) DUT (.clk(clk), .reset(reset),
    .strap_sel(strap_sel), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .threshold_select(threshold_select), .angle_enable(angle_enable), .conv_valid(conv_valid),
    .conv_channel(conv_channel), .conv_data(conv_data), .target_address(target_address),
    .second_offset_or_z_high_limit(limit), .second_offset_active(ofs_act),
    .z_high_limit_active(zl_act));
  conv_source u_src (.clk(clk), .conv_valid(conv_valid), .conv_channel(conv_channel),
    .conv_data(conv_data));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    // only the shared byte and the address register take writes
    if (a == OFS_SHARED || a == OFS_ADDR) mdl[a] = v;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(negedge clk);
    while (reg_rd_valid !== 1'b1 && n < 5)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(reg_rd_valid), 16'h0001);
    chk(16'(reg_rdata), 16'(mdl[a]));
  endtask : rd
  task automatic do_reset(input strap_t s);
    @(posedge clk);
    reset     <= 1'b1;
    strap_sel <= s;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(negedge clk);
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[13] = {4'h0, VC, 2'h0};
    {mdl[15], mdl[14]} = MC;
    chk(16'(target_address), 16'(7'h34 + 7'(s)));
  endtask : do_reset
  initial
  begin
    for (int s = 0; s < 4; s++)
    begin
      do_reset(strap_t'(s));
      for (int a = 11; a < 24; a++) rd(8'(a));
    end
    for (int a = 13; a < 22; a++) wr(8'(a), 8'($random(seed)));
    for (int a = 13; a < 22; a++) rd(8'(a));
    for (int c = 0; c < 4; c++)
    begin
      d = 16'($random(seed));
      u_src.convert(2'(c), d);
      if (c < 3) {mdl[16 + 2 * c], mdl[17 + 2 * c]} = d;
    end
    for (int a = 16; a < 22; a++) rd(8'(a));
    wr(OFS_ADDR, 8'h54);
    repeat (3) @(negedge clk);
    chk(16'(target_address), 16'h0037);
    wr(OFS_ADDR, 8'h55);
    repeat (3) @(negedge clk);
    chk(16'(target_address), 16'h002A);
    rd(OFS_ADDR);
    for (int i = 0; i < 16; i++)
    begin
      d = 16'($random(seed));
      if (i % 4 == 0) wr(OFS_SHARED, d[7:0]);
      @(posedge clk);
      threshold_select <= 2'(i);
      angle_enable     <= 2'(i / 4);
      repeat (3) @(negedge clk);
      chk(limit, {{8{mdl[11][7]}}, mdl[11]});
      chk(16'(ofs_act), 16'(threshold_select != 2'h2));
      chk(16'(zl_act), 16'(threshold_select == 2'h2 && angle_enable == 2'h0));
    end
    rd(OFS_SHARED);
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule : sensor_id_addr_result_regs_tb_top
